/* File: verilog/accel_pkg.sv */
package accel_pkg;

  // ==========================================================
  // clocking and timing
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned CTRL_CLK_HZ = 10_000_000;
  localparam int unsigned TICK_DIV = CORE_CLK_HZ / CTRL_CLK_HZ;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
  localparam int unsigned REPORT_PERIOD_MS = 1000;
  localparam int unsigned REPORT_CYCLES = (CORE_CLK_HZ / 1000) * REPORT_PERIOD_MS;

  // ==========================================================
  // register bus
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_IDENT = 8'h10;
  localparam logic [7:0] REG_AXIS_X = 8'h14;
  localparam logic [7:0] REG_AXIS_Y = 8'h18;
  localparam logic [7:0] REG_AXIS_Z = 8'h1c;
  localparam logic [7:0] REG_EVENT = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned INT_W = 3;
  localparam int unsigned INT_SAMPLE_BIT = 0;
  localparam int unsigned INT_IDENT_BIT = 1;
  localparam int unsigned INT_BUTTON_BIT = 2;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;

  // ==========================================================
  // sensor map and values
  localparam logic [5:0] SEN_ADDR_IDENT = 6'h00;
  localparam logic [5:0] SEN_ADDR_RATE = 6'h2c;
  localparam logic [5:0] SEN_ADDR_POWER = 6'h2d;
  localparam logic [5:0] SEN_ADDR_EVENT = 6'h30;
  localparam logic [5:0] SEN_ADDR_FORMAT = 6'h31;
  localparam logic [5:0] SEN_ADDR_AXES = 6'h32;
  localparam logic [7:0] FORMAT_VALUE = 8'h40;
  localparam logic [7:0] RATE_400HZ = 8'h0c;
  localparam logic [7:0] POWER_MEASURE = 8'h08;
  localparam logic [2:0] AXIS_BYTES = 3'h6;
  localparam int unsigned EVT_SAMPLE_READY = 7;
  localparam int unsigned EVT_SINGLE_KNOCK = 6;
  localparam int unsigned EVT_DOUBLE_KNOCK = 5;
  localparam int unsigned EVT_ACTIVITY = 4;
  localparam int unsigned EVT_INACTIVITY = 3;
  localparam int unsigned EVT_FREE_FALL = 2;
  localparam int unsigned EVT_WATERMARK = 1;
  localparam int unsigned EVT_OVERRUN = 0;
  localparam int unsigned RD_W = 48;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FORMAT, ST_RATE, ST_POWER, ST_IDENT, ST_WAIT, ST_EVENT, ST_AXES
  } ctrl_state_t;

endpackage

/* File: verilog/three_wire_shifter.sv */
`timescale 1ns/1ps
module three_wire_shifter
  import accel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  // request
  input wire logic start,
  input wire logic read,
  input wire logic [2:0] nbytes,
  input wire logic [7:0] cmd,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [RD_W-1:0] rdata,
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic sdio_i
);
  logic active;
  logic read_mode;
  logic [5:0] bit_cnt;
  logic [5:0] bit_total;
  logic [15:0] out_sh;
  logic rx_phase;

  assign busy = active;
  assign rx_phase = read_mode && (bit_cnt >= 6'h08);

  // ==========================================================
  // frame sequencing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      read_mode <= 1'b0;
      bit_cnt <= 6'h00;
      bit_total <= 6'h00;
      out_sh <= 16'h0000;
      cs_n <= 1'b1;
      sclk <= 1'b1;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!active)
      begin
        if (start)
        begin
          active <= 1'b1;
          read_mode <= read;
          bit_cnt <= 6'h00;
          bit_total <= read ? 6'({nbytes, 3'b000} + 6'h08) : 6'h10;
          out_sh <= {cmd, wdata};
          cs_n <= 1'b0;
        end
      end
      else if (tick)
      begin
        if (sclk)
        begin
          if (bit_cnt == bit_total)
          begin
            active <= 1'b0;
            cs_n <= 1'b1;
            sdio_oe <= 1'b0;
            done <= 1'b1;
          end
          else
          begin
            sclk <= 1'b0;
            sdio_o <= out_sh[15];
            out_sh <= {out_sh[14:0], 1'b0};
            sdio_oe <= !rx_phase;
          end
        end
        else
        begin
          sclk <= 1'b1;
          bit_cnt <= 6'(bit_cnt + 6'h01);
        end
      end
    end
  end

  // ==========================================================
  // receive shift on rising edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= '0;
    else if (!active && start)
      rdata <= '0;
    else if (active && tick && !sclk && rx_phase)
      rdata <= {rdata[RD_W-2:0], sdio_i};
  end

endmodule

/* File: verilog/accel_three_wire_spi_reader.sv */
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module accel_three_wire_spi_reader
#(
  parameter int unsigned REPORT_PERIOD_CYCLES = accel_pkg::REPORT_CYCLES
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // axi4-lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [accel_pkg::AXI_AW-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // axi4-lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [accel_pkg::AXI_DW-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  // axi4-lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [accel_pkg::AXI_AW-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // axi4-lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [accel_pkg::AXI_DW-1:0] RDATA,
  output logic [1:0] RRESP,
  // interrupt
  output logic IRQ,
  // pushbuttons, low when pressed
  input wire logic PUSHBUTTON_ZERO_N,
  input wire logic PUSHBUTTON_ONE_N,
  // sensor link
  output logic SCLK,
  output logic CS_N,
  output logic SDIO_O,
  output logic SDIO_OE,
  input wire logic SDIO_I
);
  import accel_pkg::*;

  ctrl_state_t state;
  logic [3:0] tick_cnt;
  logic tick;
  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [AXI_DW-1:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic ctrl_start;
  logic ctrl_stop;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  logic [AXI_DW-1:0] rd_word;
  logic [7:0] ident;
  logic [7:0] event_byte;
  logic [15:0] axis_x;
  logic [15:0] axis_y;
  logic [15:0] axis_z;
  logic ident_valid;
  logic btn0_prev;
  logic btn1_prev;
  logic button_press;
  logic stop_req;
  logic [31:0] period_cnt;
  logic period_due;
  logic launched;
  logic is_cmd;
  logic eng_start;
  logic eng_read;
  logic [2:0] eng_nbytes;
  logic [7:0] eng_cmd;
  logic [7:0] eng_wdata;
  logic eng_busy;
  logic eng_done;
  logic [RD_W-1:0] eng_rdata;
  logic step_done;

  function automatic logic addr_known(input logic [AXI_AW-1:0] a);
    addr_known = (a == REG_CONTROL) || (a == REG_STATUS) || (a == REG_INT_STATUS) ||
                 (a == REG_INT_MASK) || (a == REG_IDENT) || (a == REG_AXIS_X) ||
                 (a == REG_AXIS_Y) || (a == REG_AXIS_Z) || (a == REG_EVENT);
  endfunction

  function automatic logic [7:0] build_cmd(input logic rd, input logic multi, input logic [5:0] a);
    build_cmd = {rd, multi, a};
  endfunction

  // ==========================================================
  // 10 mhz enable
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      tick_cnt <= 4'h0;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= 4'h0;
    else
      tick_cnt <= 4'(tick_cnt + 4'h1);
  end

  assign tick = (tick_cnt == TICK_LAST);

  // ==========================================================
  // axi4-lite write path
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign wr_fire = aw_held && w_held && !BVALID;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  assign ctrl_start = wr_fire && (aw_addr == REG_CONTROL) && w_strb[0] && w_data[CTRL_START_BIT];
  assign ctrl_stop = wr_fire && (aw_addr == REG_CONTROL) && w_strb[0] && w_data[CTRL_STOP_BIT];

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      int_mask <= INT_MASK_RESET;
    else if (wr_fire && (aw_addr == REG_INT_MASK) && w_strb[0])
      int_mask <= w_data[INT_W-1:0];
  end

  // ==========================================================
  // axi4-lite read path
  assign ARREADY = !RVALID;
  assign rd_fire = ARVALID && ARREADY;

  always_comb
  begin
    rd_word = '0;
    if (ARADDR == REG_STATUS)
      rd_word = {29'h0, ident_valid, eng_busy, state != ST_IDLE};
    else if (ARADDR == REG_INT_STATUS)
      rd_word = {29'h0, int_status};
    else if (ARADDR == REG_INT_MASK)
      rd_word = {29'h0, int_mask};
    else if (ARADDR == REG_IDENT)
      rd_word = {24'h0, ident};
    else if (ARADDR == REG_AXIS_X)
      rd_word = {{16{axis_x[15]}}, axis_x};
    else if (ARADDR == REG_AXIS_Y)
      rd_word = {{16{axis_y[15]}}, axis_y};
    else if (ARADDR == REG_AXIS_Z)
      rd_word = {{16{axis_z[15]}}, axis_z};
    else if (ARADDR == REG_EVENT)
      rd_word = {24'h0, event_byte};
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= addr_known(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID && RREADY)
      RVALID <= 1'b0;
  end

  // ==========================================================
  // interrupt status, read clears, set wins
  assign int_clr = (rd_fire && (ARADDR == REG_INT_STATUS)) ? int_status : '0;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      int_status <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      int_status <= (int_status & ~int_clr) | int_set;
      IRQ <= |(((int_status & ~int_clr) | int_set) & int_mask);
    end
  end

  // ==========================================================
  // pushbuttons
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      btn0_prev <= 1'b1;
      btn1_prev <= 1'b1;
    end
    else
    begin
      btn0_prev <= PUSHBUTTON_ZERO_N;
      btn1_prev <= PUSHBUTTON_ONE_N;
    end
  end

  assign button_press = (btn0_prev && !PUSHBUTTON_ZERO_N) || (btn1_prev && !PUSHBUTTON_ONE_N);
  assign stop_req = ((state != ST_IDLE) && button_press) || ctrl_stop;

  // ==========================================================
  // report period
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      period_cnt <= 32'h0;
      period_due <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      period_cnt <= 32'h0;
      period_due <= 1'b0;
    end
    else if (period_cnt == 32'(REPORT_PERIOD_CYCLES - 1))
    begin
      period_cnt <= 32'h0;
      period_due <= 1'b1;
    end
    else
    begin
      period_cnt <= 32'(period_cnt + 32'h1);
      if (state == ST_WAIT)
        period_due <= 1'b0;
    end
  end

  // ==========================================================
  // sensor command per step
  always_comb
  begin
    is_cmd = 1'b1;
    eng_read = 1'b0;
    eng_nbytes = 3'h1;
    eng_cmd = 8'h00;
    eng_wdata = 8'h00;
    case (state)
      ST_FORMAT:
      begin
        eng_cmd = build_cmd(1'b0, 1'b0, SEN_ADDR_FORMAT);
        eng_wdata = FORMAT_VALUE;
      end
      ST_RATE:
      begin
        eng_cmd = build_cmd(1'b0, 1'b0, SEN_ADDR_RATE);
        eng_wdata = RATE_400HZ;
      end
      ST_POWER:
      begin
        eng_cmd = build_cmd(1'b0, 1'b0, SEN_ADDR_POWER);
        eng_wdata = POWER_MEASURE;
      end
      ST_IDENT:
      begin
        eng_read = 1'b1;
        eng_cmd = build_cmd(1'b1, 1'b0, SEN_ADDR_IDENT);
      end
      ST_EVENT:
      begin
        eng_read = 1'b1;
        eng_cmd = build_cmd(1'b1, 1'b0, SEN_ADDR_EVENT);
      end
      ST_AXES:
      begin
        eng_read = 1'b1;
        eng_nbytes = AXIS_BYTES;
        eng_cmd = build_cmd(1'b1, 1'b1, SEN_ADDR_AXES);
      end
      default:
        is_cmd = 1'b0;
    endcase
  end

  assign eng_start = is_cmd && !launched && !eng_busy && !stop_req;
  assign step_done = launched && eng_done;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      launched <= 1'b0;
    else if (stop_req || eng_done)
      launched <= 1'b0;
    else if (eng_start)
      launched <= 1'b1;
  end

  // ==========================================================
  // monitoring sequence
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      state <= ST_IDLE;
    else if (stop_req)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (ctrl_start)
            state <= ST_FORMAT;
        ST_FORMAT:
          if (step_done)
            state <= ST_RATE;
        ST_RATE:
          if (step_done)
            state <= ST_POWER;
        ST_POWER:
          if (step_done)
            state <= ST_IDENT;
        ST_IDENT:
          if (step_done)
            state <= ST_WAIT;
        ST_WAIT:
          if (period_due)
            state <= ST_EVENT;
        ST_EVENT:
          if (step_done && eng_rdata[EVT_SAMPLE_READY])
            state <= ST_AXES;
        ST_AXES:
          if (step_done)
            state <= ST_WAIT;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // captured sensor data
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ident <= 8'h00;
      ident_valid <= 1'b0;
      event_byte <= 8'h00;
      axis_x <= 16'h0000;
      axis_y <= 16'h0000;
      axis_z <= 16'h0000;
    end
    else if (step_done)
    begin
      if (state == ST_IDENT)
      begin
        ident <= eng_rdata[7:0];
        ident_valid <= 1'b1;
      end
      if (state == ST_EVENT)
        event_byte <= eng_rdata[7:0];
      if (state == ST_AXES)
      begin
        axis_x <= {eng_rdata[39:32], eng_rdata[47:40]};
        axis_y <= {eng_rdata[23:16], eng_rdata[31:24]};
        axis_z <= {eng_rdata[7:0], eng_rdata[15:8]};
      end
    end
  end

  always_comb
  begin
    int_set = '0;
    int_set[INT_SAMPLE_BIT] = step_done && (state == ST_AXES);
    int_set[INT_IDENT_BIT] = step_done && (state == ST_IDENT);
    int_set[INT_BUTTON_BIT] = (state != ST_IDLE) && button_press;
  end

  // ==========================================================
  // serial engine
  three_wire_shifter u_shifter
  (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(tick),
    .start(eng_start),
    .read(eng_read),
    .nbytes(eng_nbytes),
    .cmd(eng_cmd),
    .wdata(eng_wdata),
    .busy(eng_busy),
    .done(eng_done),
    .rdata(eng_rdata),
    .sclk(SCLK),
    .cs_n(CS_N),
    .sdio_o(SDIO_O),
    .sdio_oe(SDIO_OE),
    .sdio_i(SDIO_I)
  );

endmodule

/* File: sim/accel_reader_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// bus and link checks
module accel_reader_assertions
  import accel_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [AXI_DW-1:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic IRQ,
  // sensor link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_O,
  input wire logic SDIO_OE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_sclk_idle_high: assert property (CS_N |-> SCLK)
    else $error("serial clock low outside a frame");
  a_data_on_fall: assert property (!CS_N && $past(!CS_N) && $changed(SDIO_O) |-> $fell(SCLK))
    else $error("data changed away from a falling serial edge");
  a_drive_in_frame: assert property (SDIO_OE |-> !CS_N)
    else $error("data line driven outside a frame");
  a_sclk_rate: assert property ($fell(SCLK) |-> (!SCLK) [*8] ##1 (!SCLK) [*2] ##1 SCLK)
    else $error("serial clock half period not ten cycles");
  a_first_bit: assert property ($fell(CS_N) |-> SCLK ##[1:11] (!SCLK && SDIO_OE))
    else $error("command bit not driven on first falling edge");
  a_write_resp: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
    else $error("write response not two cycles after handshake");
  a_read_resp: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data not one cycle after address");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data dropped before taken");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while data pending");
  c_frame: cover property ($fell(CS_N));
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (RVALID && RRESP == RESP_SLVERR);
endmodule
bind accel_three_wire_spi_reader accel_reader_assertions u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .IRQ(IRQ), .SCLK(SCLK), .CS_N(CS_N),
  .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE));

/* File: sim/accel_sensor_model.sv */
`timescale 1ns/1ps
// ==========================================================
// three-wire sensor at the far end of the link
module accel_sensor_model
#(
  parameter logic [7:0] IDENT_CODE = 8'h5a // arbitrary value
)
(
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  output logic sdio_i
);
  logic [7:0] regs [0:63];
  logic [7:0] sh = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] first_cmd = 8'h00;
  logic [5:0] ptr = 6'h00;
  logic drv = 1'b0;
  logic dbit = 1'b0;
  logic last = 1'b0;
  int cnt = 0;
  int polls = 0;
  int idents = 0;
  int frames = 0;
  int max_rd = 0;
  int errs = 0;
  initial
  begin
    foreach (regs[i]) regs[i] = 8'h00;
    regs[6'h00] = IDENT_CODE;
    regs[6'h32] = 8'h34;
    regs[6'h33] = 8'hff;
    regs[6'h34] = 8'h02;
    regs[6'h35] = 8'h01;
    regs[6'h36] = 8'h10;
    regs[6'h37] = 8'hfe;
  end
  // released line shows inverse of last level
  assign sdio_i = sdio_oe ? sdio_o : (drv ? dbit : ~last);
  always @(negedge cs_n)
  begin
    cnt = 0;
    frames++;
  end
  always @(posedge cs_n)
  begin
    drv = 1'b0;
    if (cmd[7] && (cnt - 8) / 8 > max_rd) max_rd = (cnt - 8) / 8;
  end
  // sample on rising edge, released wire after read command
  always @(posedge sclk) if (!cs_n)
  begin
    last = sdio_i;
    if (cnt < 8 || !cmd[7]) sh = {sh[6:0], sdio_i};
    else if (sdio_oe) errs++;
    cnt++;
    if (cnt == 8 && frames == 1) first_cmd = sh;
    if (cnt == 8) cmd = sh;
    if (cnt == 8) ptr = sh[5:0];
    if (cnt == 8 && sh == 8'h80) idents++;
    // first poll lacks only the ready flag, next one has it alone
    if (cnt == 8 && sh == 8'hb0) regs[6'h30] = polls[0] ? 8'h80 : 8'h7f;
    if (cnt == 8 && sh == 8'hb0) polls++;
    if (cnt == 16 && !cmd[7]) regs[ptr] = sh;
  end
  // drive on falling edge, auto increment in burst
  always @(negedge sclk) if (!cs_n && cnt >= 8 && cmd[7])
  begin
    if (cnt > 8 && cnt % 8 == 0 && cmd[6]) ptr++;
    dbit = regs[ptr][7 - cnt % 8];
    drv = 1'b1;
  end
endmodule

/* File: sim/tb_accel_three_wire_spi_reader.sv */
`timescale 1ns/1ps
module tb_accel_three_wire_spi_reader;
  import accel_pkg::*;
  localparam int unsigned PERIOD = 4000;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SCLK, CS_N, SDIO_O, SDIO_OE, SDIO_I;
  logic [1:0] BRESP, RRESP, r;
  logic [1:0] btn_n = 2'h3;
  time t0, t1;
  int errors = 0;
  int n_compared = 0;
  int f0;
  always #5 CORE_CLK = ~CORE_CLK;
  accel_three_wire_spi_reader #(.REPORT_PERIOD_CYCLES(PERIOD)) DUT (.CORE_CLK(CORE_CLK), .RST(RST),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID),
    .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .IRQ(IRQ), .PUSHBUTTON_ZERO_N(btn_n[0]),
    .PUSHBUTTON_ONE_N(btn_n[1]), .SCLK(SCLK), .CS_N(CS_N), .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE),
    .SDIO_I(SDIO_I));
  accel_sensor_model sensor (.sclk(SCLK), .cs_n(CS_N), .sdio_o(SDIO_O), .sdio_oe(SDIO_OE), .sdio_i(SDIO_I));
  // ==========================================================
  // verdict and compare
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    errors++;
    $display("[ERR] t=%0t got=%h exp=%h wait ran out", $time, 32'h0, 32'h1);
    print_verdict();
  endtask
  // ==========================================================
  // bus tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic aw, w, bv, b;
    n = 0;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do
    begin
      @(negedge CORE_CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      bv = BVALID;
      b = BVALID && BREADY;
      rs = BRESP;
      @(posedge CORE_CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (bv && !b) BREADY <= 1'b1;
      n++;
    end while (b !== 1'b1 && n < 100);
    BREADY <= 1'b0;
    if (n >= 100) timed_out();
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ar, rv, rt;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do
    begin
      @(negedge CORE_CLK);
      ar = ARVALID && ARREADY;
      rv = RVALID;
      rt = RVALID && RREADY;
      v = RDATA;
      rs = RRESP;
      @(posedge CORE_CLK);
      if (ar) ARVALID <= 1'b0;
      if (rv && !rt) RREADY <= 1'b1;
      n++;
    end while (rt !== 1'b1 && n < 100);
    RREADY <= 1'b0;
    if (n >= 100) timed_out();
  endtask
  task automatic wait_irq(output time t);
    int n;
    n = 0;
    do
    begin
      @(negedge CORE_CLK);
      n++;
    end while (IRQ !== 1'b1 && n < 3 * PERIOD);
    t = $time;
    @(posedge CORE_CLK);
    if (IRQ !== 1'b1) timed_out();
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    check_val({31'h0, SCLK}, 32'h1);
    axi_read(REG_INT_MASK, d, r);
    check_val(d, {29'h0, INT_MASK_RESET});
    axi_read(REG_STATUS, d, r);
    check_val(d, 32'h0);
    axi_read(8'h3c, d, r);
    check_val({d[31:2], r}, {30'h0, RESP_SLVERR});
    axi_write(8'h3c, 32'h1, r);
    check_val({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test reset and map done");
    axi_write(REG_CONTROL, 32'h1 << CTRL_START_BIT, r);
    for (int n = 0; n < 1000 && d[2] !== 1'b1; n++) axi_read(REG_STATUS, d, r);
    check_val(d & 32'h5, 32'h5);
    check_val({24'h0, sensor.first_cmd}, {26'h0, SEN_ADDR_FORMAT});
    check_val({24'h0, sensor.regs[6'h31]}, 32'h40);
    check_val({24'h0, sensor.regs[6'h2c]}, {24'h0, RATE_400HZ});
    axi_read(REG_IDENT, d, r);
    check_val(d, 32'h5a);
    axi_write(REG_INT_MASK, 32'h1 << INT_SAMPLE_BIT, r);
    repeat (2) @(posedge CORE_CLK);
    check_val({31'h0, IRQ}, 32'h0);
    $display("test initialisation done");
    wait_irq(t0);
    axi_read(REG_INT_STATUS, d, r);
    check_val(d, 32'h3);
    repeat (2) @(posedge CORE_CLK);
    check_val({31'h0, IRQ}, 32'h0);
    axi_read(REG_AXIS_X, d, r);
    check_val(d, 32'hffffff34);
    axi_read(REG_AXIS_Y, d, r);
    check_val(d, 32'h00000102);
    axi_read(REG_AXIS_Z, d, r);
    check_val(d, 32'hfffffe10);
    axi_read(REG_EVENT, d, r);
    check_val(d, 32'h80);
    check_val(32'(sensor.polls), 32'd2);
    check_val(32'(sensor.max_rd), 32'd6);
    check_val(32'(sensor.idents), 32'd1);
    wait_irq(t1);
    check_val(32'((t1 - t0) / 10), PERIOD);
    check_val(32'(sensor.errs), 32'd0);
    $display("test reporting done");
    for (int b = 0; b < 2; b++)
    begin
      axi_write(REG_INT_MASK, 32'h1 << INT_BUTTON_BIT, r);
      if (b == 1) axi_write(REG_CONTROL, 32'h1 << CTRL_START_BIT, r);
      repeat (200) @(posedge CORE_CLK);
      btn_n[b] <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      btn_n[b] <= 1'b1;
      wait_irq(t0);
      axi_read(REG_INT_STATUS, d, r);
      check_val(d & 32'h4, 32'h4);
      axi_read(REG_STATUS, d, r);
      check_val(d & 32'h1, 32'h0);
    end
    axi_write(REG_CONTROL, 32'h1 << CTRL_START_BIT, r);
    repeat (200) @(posedge CORE_CLK);
    axi_read(REG_STATUS, d, r);
    check_val(d & 32'h3, 32'h3);
    axi_write(REG_CONTROL, 32'h1 << CTRL_STOP_BIT, r);
    axi_read(REG_STATUS, d, r);
    check_val(d & 32'h1, 32'h0);
    f0 = sensor.frames;
    repeat (PERIOD + 200) @(posedge CORE_CLK);
    check_val(32'(sensor.frames - f0), 32'd0);
    $display("test pushbutton stop done");
    print_verdict();
  end
endmodule
